// [rtl/hbp_pkg.sv]
// Package for the heartbeat and panel control block: register map, field layouts, timing.
// Assumes a single 10 MHz system clock.
`default_nettype none
package hbp_pkg;
   localparam int          CLK_HZ          = 10_000_000;
   localparam logic [26:0] HB_TYPE_ADDR    = 27'h4000c00;
   localparam int          HB_TYPE_W       = 2;
   localparam logic [1:0]  HB_TYPE_RST     = 2'h0;
   localparam int          IVL_W           = 4;
   localparam int          CNT_W           = 24;
   localparam int          HB_IVL_US       = 10300;
   localparam int          HB_IVL_CYC      = (HB_IVL_US * (CLK_HZ / 1_000_000));
   localparam int          ID_CHASSIS_HI   = 7;
   localparam int          ID_CHASSIS_LO   = 6;
   localparam int          NUM_GATEWAYS    = 8;
   localparam int          SVC_W           = 2;
   localparam logic [3:0]  IVL_DEFAULT_SEL = 4'h0;

   typedef enum logic [1:0]
   {
      CLK_OSC0 = 2'b00,
      CLK_OSC1 = 2'b01,
      CLK_OSC2 = 2'b10,
      CLK_EXT  = 2'b11
   } hbp_clksrc_t;

   typedef struct packed
   {
      logic [NUM_GATEWAYS-1:0] lowSpeedEn;
      hbp_clksrc_t             clkSrc;
      logic [1:0]              sysSize;
      logic [1:0]              chassis;
      logic [IVL_W-1:0]        interval;
      logic                    hbEnable;
      logic [SVC_W-1:0]        hbService;
   } hbp_panel_t;

   localparam int PANEL_W = $bits(hbp_panel_t);

   typedef struct packed
   {
      logic                     wr;
      logic [26:0]              addr;
      logic [HB_TYPE_W-1:0]     data;
   } hbp_cpuwr_t;
endpackage : hbp_pkg
`default_nettype wire

// [rtl/hbp_sync.sv]
// Two-flop synchroniser for a vector of panel inputs.
// Assumes inputs are static or slow relative to the clock.
`default_nettype none
module hbp_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1_ff;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1_ff <= '0;
         dout      <= '0;
      end
      else
      begin
         stage1_ff <= din;
         dout      <= stage1_ff;
      end
   end
endmodule : hbp_sync
`default_nettype wire

// [rtl/hbp_heartbeat_panel.sv]
// Heartbeat generator with control panel settings and remote panel access.
// Assumes panel switches and remote frames are outside the clock domain; the
// gateway processor write port is synchronous to clock.
// How it works
// - Two-bit write-only heartbeat type register, present only in a gateway input node.
// - A written type applies from the next heartbeat, never one in progress.
// - Low two data bits plus one give the heartbeat pulse width in clock periods.
// - Each gateway low-speed channel enable follows its panel setting.
// - Chassis setting drives identity bits 7:6 locally and for the neighbour.
// - Clock source picks one of three oscillators or the external generator.
// - System size setting drives board configuration options.
// - Heartbeats are spaced by the configured interval, 10.3 ms by default.
// - With heartbeat disabled no heartbeat events are generated.
// - Gateway heartbeat requests are serviced at the selected service rate.
// - Remote access off: remote reads answered, remote writes refused.
// - Remote access off: local panel settings override remote ones.
`default_nettype none
module hbp_heartbeat_panel
   import hbp_pkg::*;
#(
   parameter bit          INPUT_NODE = 1'b1,
   parameter int unsigned IVL_CYC    = HB_IVL_CYC
) (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire hbp_pkg::hbp_cpuwr_t       cpuWr,
   input  wire hbp_pkg::hbp_panel_t       panelIn,
   input  wire logic                      remoteEnable,
   input  wire logic                      remoteWr,
   input  wire logic                      remoteRd,
   input  wire hbp_pkg::hbp_panel_t       remoteData,
   input  wire logic [hbp_pkg::NUM_GATEWAYS-1:0] gwHbReq,
   output logic                           heartbeat,
   output logic [hbp_pkg::NUM_GATEWAYS-1:0] gwHbAck,
   output logic [hbp_pkg::NUM_GATEWAYS-1:0] lowSpeedChanEn,
   output logic [1:0]                     localIdHi,
   output logic [1:0]                     neighbourIdHi,
   output hbp_pkg::hbp_clksrc_t           clockSource,
   output logic [1:0]                     boardConfigSize,
   output hbp_pkg::hbp_panel_t            remoteRdData,
   output logic                           remoteRdValid,
   output logic                           remoteWrRefused
);
   import hbp_pkg::*;

   typedef enum logic [1:0]
   {
      HB_IDLE  = 2'b00,
      HB_PULSE = 2'b01
   } hbp_state_t;

   hbp_panel_t panelSync;
   logic [2:0] remSync;
   logic [2:0] remSyncD_ff;

   hbp_sync #(.W(PANEL_W + 3)) u_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   ({panelIn, remoteEnable, remoteWr, remoteRd}),
      .dout  ({panelSync, remSync})
   );

   // Remote settings word crosses in too; it settles before the strobe edge is seen
   hbp_panel_t remDataSync;

   hbp_sync #(.W(PANEL_W)) u_data_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   (remoteData),
      .dout  (remDataSync)
   );

   wire remEn   = remSync[2];
   wire remWrPl = remSync[1] & ~remSyncD_ff[1];
   wire remRdPl = remSync[0] & ~remSyncD_ff[0];

   // Remote settings store and effective selection
   hbp_panel_t remote_ff;
   logic       remoteHeld_ff;
   wire        acceptRemWr = remWrPl & remEn;
   wire        useRemote   = remEn & remoteHeld_ff;
   hbp_panel_t cfg;
   assign cfg = useRemote ? remote_ff : panelSync;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         remSyncD_ff     <= 3'h0;
         remote_ff       <= '0;
         remoteHeld_ff   <= 1'b0;
         remoteRdData    <= '0;
         remoteRdValid   <= 1'b0;
         remoteWrRefused <= 1'b0;
      end
      else
      begin
         remSyncD_ff     <= remSync;
         remoteRdValid   <= remRdPl;
         remoteWrRefused <= remWrPl & ~remEn;
         if (remRdPl)
            remoteRdData <= cfg;
         if (acceptRemWr)
         begin
            remote_ff     <= remDataSync;
            remoteHeld_ff <= 1'b1;
         end
      end
   end

   // Panel-driven outputs
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         lowSpeedChanEn  <= '0;
         localIdHi       <= 2'h0;
         neighbourIdHi   <= 2'h0;
         clockSource     <= CLK_OSC0;
         boardConfigSize <= 2'h0;
      end
      else
      begin
         lowSpeedChanEn  <= cfg.lowSpeedEn;
         localIdHi       <= cfg.chassis;
         neighbourIdHi   <= cfg.chassis ^ 2'h1;
         clockSource     <= cfg.clkSrc;
         boardConfigSize <= cfg.sysSize;
      end
   end

   // Heartbeat type register
   logic [HB_TYPE_W-1:0] hbType_ff;
   wire typeWr = INPUT_NODE & cpuWr.wr & (cpuWr.addr == HB_TYPE_ADDR);

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         hbType_ff <= HB_TYPE_RST;
      else if (typeWr)
         hbType_ff <= cpuWr.data[HB_TYPE_W-1:0];
   end

   // Interval: each step of selector bits 2:0 doubles the spacing; bit 3 is ignored
   logic [CNT_W-1:0] ivlCnt_ff;
   logic [CNT_W-1:0] ivlTarget;
   assign ivlTarget = CNT_W'((IVL_CYC << cfg.interval[2:0]) - 1);
   wire ivlDone = (ivlCnt_ff >= ivlTarget);

   hbp_state_t       state_ff;
   hbp_state_t       nxt_state;
   logic [2:0]       width_ff;
   logic [2:0]       widthCnt_ff;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         HB_IDLE:
            if (cfg.hbEnable && ivlDone)
               nxt_state = HB_PULSE;
         HB_PULSE:
            if (widthCnt_ff == width_ff)
               nxt_state = HB_IDLE;
         default:
            nxt_state = HB_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff    <= HB_IDLE;
         ivlCnt_ff   <= '0;
         width_ff    <= 3'h1;
         widthCnt_ff <= 3'h1;
      end
      else
      begin
         state_ff <= nxt_state;
         if (!cfg.hbEnable || (state_ff == HB_IDLE && ivlDone))
            ivlCnt_ff <= '0;
         else
            ivlCnt_ff <= ivlCnt_ff + CNT_W'(1);
         if (state_ff == HB_IDLE && nxt_state == HB_PULSE)
         begin
            // Latched at pulse start so a late write waits for the next beat
            width_ff    <= {1'b0, hbType_ff} + 3'h1;
            widthCnt_ff <= 3'h1;
         end
         else if (state_ff == HB_PULSE)
            widthCnt_ff <= widthCnt_ff + 3'h1;
      end
   end

   assign heartbeat = (state_ff == HB_PULSE);

   // Gateway request service: round robin, one grant per service tick
   logic [13:0] svcCnt_ff;
   logic [2:0]  rrPtr_ff;
   wire [13:0]  svcLimit = 14'h00ff << {cfg.hbService, 1'b0};
   wire         svcTick  = (svcCnt_ff >= svcLimit);
   logic [NUM_GATEWAYS-1:0] reqSync;

   hbp_sync #(.W(NUM_GATEWAYS)) u_req_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   (gwHbReq),
      .dout  (reqSync)
   );

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         svcCnt_ff <= 14'h0000;
         rrPtr_ff  <= 3'h0;
         gwHbAck   <= '0;
      end
      else
      begin
         gwHbAck  <= '0;
         svcCnt_ff <= svcTick ? 14'h0000 : svcCnt_ff + 14'h0001;
         if (svcTick)
         begin
            rrPtr_ff <= rrPtr_ff + 3'h1;
            if (reqSync[rrPtr_ff])
               gwHbAck[rrPtr_ff] <= 1'b1;
         end
      end
   end

   property p_no_hb_disabled;
      @(posedge clock) disable iff (!rstn)
      (state_ff == HB_IDLE && !cfg.hbEnable) |=> !heartbeat;
   endproperty
   a_no_hb_disabled: assert property (p_no_hb_disabled) else $error("heartbeat while disabled");

   property p_width;
      @(posedge clock) disable iff (!rstn)
      $rose(heartbeat) && width_ff == 3'h1 |=> !heartbeat;
   endproperty
   a_width: assert property (p_width) else $error("one-period heartbeat too long");

   sequence s_beat4_start;
      $rose(heartbeat) && width_ff == 3'h4;
   endsequence

   sequence s_four_high;
      heartbeat [*4] ##1 !heartbeat;
   endsequence

   property p_width4;
      @(posedge clock) disable iff (!rstn)
      s_beat4_start |-> s_four_high;
   endproperty
   a_width4: assert property (p_width4) else $error("four-period heartbeat wrong");

   property p_type_stable;
      @(posedge clock) disable iff (!rstn)
      heartbeat && $past(heartbeat) |-> $stable(width_ff);
   endproperty
   a_type_stable: assert property (p_type_stable) else $error("width changed mid heartbeat");

   property p_type_wr;
      @(posedge clock) disable iff (!rstn)
      typeWr |=> hbType_ff == $past(cpuWr.data);
   endproperty
   a_type_wr: assert property (p_type_wr) else $error("type register not updated");

   property p_remote_refused;
      @(posedge clock) disable iff (!rstn)
      remWrPl && !remEn |=> remoteWrRefused && $stable(remote_ff);
   endproperty
   a_remote_refused: assert property (p_remote_refused) else $error("remote write accepted");

   property p_local_wins;
      @(posedge clock) disable iff (!rstn)
      !remEn |=> localIdHi == $past(panelSync.chassis);
   endproperty
   a_local_wins: assert property (p_local_wins) else $error("remote overrides panel");

   property p_lsp;
      @(posedge clock) disable iff (!rstn)
      !useRemote |=> lowSpeedChanEn == $past(panelSync.lowSpeedEn);
   endproperty
   a_lsp: assert property (p_lsp) else $error("channel enable mismatch");

   property p_neighbour;
      @(posedge clock) disable iff (!rstn)
      1'b1 |=> (neighbourIdHi ^ localIdHi) == 2'h1;
   endproperty
   a_neighbour: assert property (p_neighbour) else $error("neighbour identity mismatch");

   property p_ack_onehot;
      @(posedge clock) disable iff (!rstn)
      $onehot0(gwHbAck);
   endproperty
   a_ack_onehot: assert property (p_ack_onehot) else $error("several gateway grants at once");

   property p_start_width;
      @(posedge clock) disable iff (!rstn)
      $rose(heartbeat) |-> width_ff == ({1'b0, $past(hbType_ff)} + 3'h1);
   endproperty
   a_start_width: assert property (p_start_width) else $error("pulse width not from type");
endmodule : hbp_heartbeat_panel
`default_nettype wire

// [testbench/hbp_pe_model.sv]
// Processing-element side of the heartbeat: measures each pulse's width and start-to-start spacing.
// Assumes heartbeat is synchronous to clock and changes just after a rising edge.
`default_nettype none
module hbp_pe_model (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        heartbeat,
   output logic      [15:0] lastWidth,
   output logic      [15:0] lastGap,
   output logic      [15:0] beats
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] widthCnt;
   logic [15:0] gapCnt;
   logic        prevHb;
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         {lastWidth, lastGap, beats, widthCnt, gapCnt, prevHb} <= '0;
      end
      else
      begin
         prevHb <= heartbeat;
         gapCnt <= gapCnt + 16'h1;
         if (heartbeat)
            widthCnt <= widthCnt + 16'h1;
         if (heartbeat && !prevHb)
         begin
            lastGap  <= gapCnt;
            gapCnt   <= 16'h1;
            widthCnt <= 16'h1;
            beats    <= beats + 16'h1;
         end
         if (!heartbeat && prevHb)
            lastWidth <= widthCnt;
      end
   end
endmodule : hbp_pe_model
`default_nettype wire

// [testbench/hbp_heartbeat_panel_tb.sv]
// Testbench for the heartbeat and panel control block.
// Assumes a 10 MHz clock and a shortened heartbeat interval of 20 cycles.
`default_nettype none
module hbp_heartbeat_panel_tb;
   import hbp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IVL = 20;
   logic clock, rstn, remoteEnable, remoteWr, remoteRd, heartbeat, remoteRdValid, remoteWrRefused, seen;
   hbp_cpuwr_t  cpuWr;
   hbp_panel_t  panelIn, remoteData, remoteRdData, rdv;
   hbp_clksrc_t clockSource;
   logic [7:0]  gwHbReq, gwHbAck, lowSpeedChanEn;
   logic [1:0]  localIdHi, neighbourIdHi, boardConfigSize;
   logic [15:0] lastWidth, lastGap, beats;
   int          num_errors, check_count;

   hbp_heartbeat_panel #(.INPUT_NODE(1'b1), .IVL_CYC(IVL)) dut (.clock(clock), .rstn(rstn), .cpuWr(cpuWr),
      .panelIn(panelIn), .remoteEnable(remoteEnable), .remoteWr(remoteWr), .remoteRd(remoteRd),
      .remoteData(remoteData), .gwHbReq(gwHbReq), .heartbeat(heartbeat), .gwHbAck(gwHbAck),
      .lowSpeedChanEn(lowSpeedChanEn), .localIdHi(localIdHi), .neighbourIdHi(neighbourIdHi),
      .clockSource(clockSource), .boardConfigSize(boardConfigSize), .remoteRdData(remoteRdData),
      .remoteRdValid(remoteRdValid), .remoteWrRefused(remoteWrRefused));
   hbp_pe_model pe (.clock(clock), .rstn(rstn), .heartbeat(heartbeat), .lastWidth(lastWidth),
      .lastGap(lastGap), .beats(beats));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   task automatic cpu_write(input logic [26:0] a, input logic [1:0] d);
      @(posedge clock);
      cpuWr <= '{wr: 1'b1, addr: a, data: d};
      @(posedge clock);
      cpuWr.wr <= 1'b0;
   endtask : cpu_write

   task automatic wait_beats(input int n);
      logic [15:0] tgt;
      tgt = beats + 16'(n);
      for (int i = 0; i < 2000 && beats != tgt; i++)
         cyc(1);
   endtask : wait_beats

   task automatic remote(input bit rd, output logic hit);
      hit = 1'b0;
      @(posedge clock);
      if (rd) remoteRd <= 1'b1; else remoteWr <= 1'b1;
      repeat (10)
      begin
         cyc(1);
         if ((rd ? remoteRdValid : remoteWrRefused) === 1'b1)
         begin
            hit = 1'b1;
            rdv = remoteRdData;
         end
      end
      @(posedge clock);
      remoteRd <= 1'b0;
      remoteWr <= 1'b0;
      cyc(4);
   endtask : remote

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   initial
   begin
      #(40000 * 100);
      num_errors++;
      report_and_stop;
   end

   initial
   begin
      rstn = 1'b0; cpuWr = '0; remoteEnable = 1'b0; remoteWr = 1'b0; remoteRd = 1'b0; gwHbReq = 8'h00;
      panelIn = '{lowSpeedEn: 8'ha5, clkSrc: CLK_EXT, sysSize: 2'h2, chassis: 2'h3, interval: 4'h0,
                  hbEnable: 1'b1, hbService: 2'h0};
      remoteData = panelIn;
      remoteData.chassis = 2'h1;
      cyc(20);
      chk("heartbeat in reset", 32'h0, heartbeat);
      rstn <= 1'b1;
      cyc(8);
      chk("channel enables", 32'ha5, lowSpeedChanEn);
      chk("local id", 32'h3, localIdHi);
      chk("neighbour id", 32'h2, neighbourIdHi);
      chk("board size", 32'h2, boardConfigSize);
      for (int k = 0; k < 4; k++)
      begin
         panelIn.clkSrc <= hbp_clksrc_t'(k);
         cyc(6);
         chk("clock source", 32'(k), clockSource);
      end
      $display("test panel done");
      wait_beats(2);
      cyc(6);
      chk("width type 0", 32'd1, lastWidth);
      chk("spacing", 32'(IVL), lastGap);
      cpu_write(HB_TYPE_ADDR, 2'h3);
      wait_beats(2);
      cyc(6);
      chk("width type 3", 32'd4, lastWidth);
      cpu_write(HB_TYPE_ADDR + 27'h1, 2'h0);
      wait_beats(2);
      cyc(6);
      chk("width after stray write", 32'd4, lastWidth);
      wait_beats(1);
      cpu_write(HB_TYPE_ADDR, 2'h1);
      cyc(6);
      chk("width of running pulse", 32'd4, lastWidth);
      wait_beats(1);
      cyc(6);
      chk("width of next pulse", 32'd2, lastWidth);
      panelIn.interval <= 4'h1;
      wait_beats(3);
      chk("spacing doubled", 32'(IVL * 2), lastGap);
      $display("test heartbeat done");
      remote(1'b0, seen);
      chk("write refused", 32'h1, seen);
      remote(1'b1, seen);
      chk("read answered", 32'h1, seen);
      chk("read data", 32'(panelIn), 32'(rdv));
      remoteEnable <= 1'b1;
      cyc(4);
      remote(1'b0, seen);
      chk("write taken", 32'h0, seen);
      chk("remote chassis", 32'h1, localIdHi);
      @(posedge clock);
      remoteEnable <= 1'b0;
      cyc(6);
      chk("panel chassis wins", 32'h3, localIdHi);
      $display("test remote done");
      @(posedge clock);
      panelIn.hbEnable <= 1'b0;
      cyc(10);
      chk("heartbeat idle", 32'h0, heartbeat);
      begin : disabled_run
         logic [15:0] b0;
         b0 = beats;
         cyc(120);
         chk("beats while disabled", 32'(b0), 32'(beats));
      end
      $display("test disable done");
      @(posedge clock);
      gwHbReq <= 8'h10;
      for (int i = 0; i < 2400 && gwHbAck === 8'h00; i++)
         cyc(1);
      chk("gateway grant", 32'h10, gwHbAck);
      gwHbReq <= 8'h00;
      $display("test service done");
      report_and_stop;
   end
endmodule : hbp_heartbeat_panel_tb
`default_nettype wire
